// file: design/sync_serial_defines.svh
`ifndef SYNC_SERIAL_DEFINES_SVH
`define SYNC_SERIAL_DEFINES_SVH
// register map
`define SERIAL_PORT_STATUS_ADDR 8'h94
`define SERIAL_PORT_CONTROL_ADDR 8'h14
// status fields
`define SAMPLE_PHASE_BIT 7
`define CLOCK_EDGE_BIT 6
`define BUFFER_FULL_BIT 0
`define STATUS_RESET 8'h00
`define STATUS_WRITE_MASK 8'hc0
// control fields
`define CTRL_ENABLE_BIT 5
`define CTRL_IDLE_POL_BIT 4
`define CTRL_MODE_BIT 0
`define CONTROL_RESET 8'h00
// slow clock divider for master sck, in core cycles per half period
`define HALF_PERIOD_CYCLES 4'd8
`endif

// file: design/sync_serial_pkg.sv
package sync_serial_pkg;
  // port personality, exactly one at a time
  typedef enum logic {mode_spi, mode_i2c} port_mode_t;
endpackage

// file: design/skid_buffer.sv
`timescale 1ns/10ps
`default_nettype none
// two-entry buffer between receive shifter and software
module skid_buffer (
  // clocking
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data
);
  logic [7:0] slot [0:1]; // storage
  logic [1:0] count; // number held
  logic rd_ptr; // head slot
  logic wr_ptr; // tail slot
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data = slot[rd_ptr];
  // pointer and count update
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count <= 2'd0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
    end else if (clock_enable) begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
  // data store, no reset needed
  always_ff @(posedge clock) begin
    if (clock_enable && push) slot[wr_ptr] <= in_data;
  end
  a_buf_no_overflow: assert property (@(posedge clock) disable iff (reset)
    count <= 2'd2) else $error("buffer count exceeds two");
endmodule
`default_nettype wire

// file: design/sync_serial_port.sv
// Chosen here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "sync_serial_defines.svh"
module sync_serial_port
  import sync_serial_pkg::*;
(
  // clocking
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  // register port
  input wire logic [7:0] address,
  input wire logic [7:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [7:0] read_data,
  // spi pins
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic sdi,
  output logic sdo,
  // i2c slew control
  output logic slew_control_enable,
  // received byte stream
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data
);
  logic [7:0] status_cfg; // writable upper bits
  logic [7:0] control; // mode, enable, idle polarity, master
  logic [1:0] sck_sync; // two-flop synchroniser
  logic [1:0] sdi_sync;
  logic sck_prev; // for edge detect
  logic [3:0] div_count; // master half period counter
  logic sck_gen; // master generated clock
  logic [7:0] tx_shift; // launch shifter
  logic [7:0] rx_shift; // capture shifter
  logic [2:0] bit_count; // bits captured
  logic push_valid; // byte ready for buffer
  logic push_ready;
  logic [7:0] push_data;
  logic buf_valid;
  logic [7:0] buf_data;
  logic [7:0] next_read;
  // decode
  port_mode_t mode;
  assign mode = control[`CTRL_MODE_BIT] ? mode_i2c : mode_spi;
  wire enabled = control[`CTRL_ENABLE_BIT];
  wire is_master = control[1];
  wire idle_pol = control[`CTRL_IDLE_POL_BIT];
  wire edge_sel = status_cfg[`CLOCK_EDGE_BIT];
  wire sample_sel = status_cfg[`SAMPLE_PHASE_BIT];
  wire hit_status = (address == `SERIAL_PORT_STATUS_ADDR);
  wire hit_control = (address == `SERIAL_PORT_CONTROL_ADDR);
  wire spi_on = enabled && (mode == mode_spi);
  // clock seen by shifters: generated in master, pin in slave
  wire sck_now = is_master ? sck_gen : sck_sync[1];
  wire sck_last = sck_prev;
  wire rise = sck_now && !sck_last;
  wire fall = !sck_now && sck_last;
  // launch edge: idle-going edge when edge bit low relative to idle
  wire launch_rising = edge_sel ^ idle_pol;
  wire launch_edge = launch_rising ? rise : fall;
  wire capture_edge = launch_rising ? fall : rise;
  // sample at end (next launch) or middle (capture edge), master only
  wire end_sample = is_master && sample_sel;
  wire take_bit = spi_on && (end_sample ? launch_edge : capture_edge);
  wire byte_done = take_bit && push_ready && (bit_count == 3'd7); // last bit of a byte
  wire [7:0] status_view = {status_cfg[7:6], 5'b0_0000, buf_valid};
  // next capture value, msb first
  assign push_data = {rx_shift[6:0], sdi_sync[1]};
  // register read mux
  assign next_read = hit_status ? status_view :
                     hit_control ? control :
                     8'h00;
  // input synchronisers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sck_sync <= 2'b00;
      sdi_sync <= 2'b00;
      sck_prev <= 1'b0;
    end else if (clock_enable) begin
      sck_sync <= {sck_sync[0], sck_in};
      sdi_sync <= {sdi_sync[0], sdi};
      sck_prev <= sck_now;
    end
  end
  // register writes; status keeps low six bits under hardware
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      status_cfg <= `STATUS_RESET;
      control <= `CONTROL_RESET;
    end else if (clock_enable && write_strobe) begin
      if (hit_status) status_cfg <= write_data & `STATUS_WRITE_MASK;
      else if (hit_control) control <= write_data;
    end
  end
  // read data one cycle after strobe
  always_ff @(posedge clock or posedge reset) begin
    if (reset) read_data <= 8'h00;
    else if (clock_enable) read_data <= read_strobe ? next_read : 8'h00;
  end
  // master clock generator, idles at polarity
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      div_count <= 4'd0;
      sck_gen <= 1'b0;
    end else if (clock_enable) begin
      if (!(spi_on && is_master)) begin
        div_count <= 4'd0;
        sck_gen <= idle_pol;
      end else if (div_count == `HALF_PERIOD_CYCLES - 4'd1) begin
        div_count <= 4'd0;
        sck_gen <= ~sck_gen;
      end else begin
        div_count <= div_count + 4'd1;
      end
    end
  end
  // pin drivers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
      sdo <= 1'b0;
      slew_control_enable <= 1'b0;
    end else if (clock_enable) begin
      sck_out <= sck_gen;
      sck_oe <= spi_on && is_master;
      if (spi_on && launch_edge) sdo <= tx_shift[7];
      slew_control_enable <= enabled && (mode == mode_i2c) && !sample_sel;
    end
  end
  // shifters and byte assembly
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tx_shift <= 8'h00;
      rx_shift <= 8'h00;
      bit_count <= 3'd0;
      push_valid <= 1'b0;
    end else if (clock_enable) begin
      if (push_valid && push_ready) push_valid <= 1'b0;
      // transmit echoes the last finished byte during the next frame
      if (write_strobe && hit_control) tx_shift <= 8'h00;
      else if (byte_done) tx_shift <= push_data;
      else if (spi_on && launch_edge) tx_shift <= {tx_shift[6:0], 1'b0};
      if (take_bit && push_ready) begin
        rx_shift <= push_data;
        bit_count <= bit_count + 3'd1;
        if (bit_count == 3'd7) push_valid <= 1'b1;
      end
    end
  end
  // two-entry buffer absorbs a stalled reader
  skid_buffer u_buffer (
    .clock(clock),
    .reset(reset),
    .clock_enable(clock_enable),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(rx_shift),
    .out_valid(buf_valid),
    .out_ready(rx_ready && rx_valid),
    .out_data(buf_data)
  );
  // registered stream output
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else if (clock_enable) begin
      rx_valid <= buf_valid && !(rx_valid && rx_ready);
      rx_data <= buf_data;
    end
  end
  // register view keeps the low status bits under hardware
  a_status_low_zero: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && read_strobe && hit_status) |=>
    (read_data[5:0] == {5'h00, $past(buf_valid)}))
    else $error("status low bits not under hardware");
  // slew control follows the sample bit in i2c
  a_slew_follow: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && enabled && mode == mode_i2c && sample_sel) |=> !slew_control_enable)
    else $error("slew control not disabled");
  // launch edge against idle polarity and edge bit
  a_launch_select: assert property (@(posedge clock) disable iff (reset)
    (!idle_pol && rise) |-> (launch_edge == edge_sel)) else $error("launch edge wrong");
  a_launch_idle_high: assert property (@(posedge clock) disable iff (reset)
    (idle_pol && fall) |-> (launch_edge == edge_sel)) else $error("launch edge wrong idle high");
  a_read_clear: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && !read_strobe) |=> read_data == 8'h00) else $error("read data stuck");
  // i2c slew control and spi clock drive never together
  a_mode_unique: assert property (@(posedge clock) disable iff (reset)
    !(slew_control_enable && sck_oe)) else $error("both modes active");
  a_oe_master: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && !spi_on) |=> !sck_oe) else $error("sck driven while off");
  // generated clock only toggles at the end of a half period
  a_gen_hold: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && spi_on && is_master && div_count != `HALF_PERIOD_CYCLES - 4'd1) |=>
    $stable(sck_gen)) else $error("master clock toggled early");
  // a finished byte is queued for transmit
  a_tx_echo: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && byte_done && !(write_strobe && hit_control)) |=>
    (tx_shift == $past(push_data))) else $error("finished byte not queued");
  a_sample_end: assert property (@(posedge clock) disable iff (reset)
    (take_bit && end_sample) |-> launch_edge) else $error("sample not at end");
  a_sample_mid: assert property (@(posedge clock) disable iff (reset)
    (take_bit && !end_sample) |-> capture_edge) else $error("sample not at middle");
  // scenario coverage
  c_byte_done: cover property (@(posedge clock) push_valid && push_ready);
  c_master_end: cover property (@(posedge clock) take_bit && end_sample);
  c_stall: cover property (@(posedge clock) push_valid && !push_ready);
  c_i2c_slew: cover property (@(posedge clock) slew_control_enable);
endmodule
`default_nettype wire

// file: test/spi_far_end.sv
`timescale 1ns/10ps
`default_nettype none
// far-side spi controller model feeding the port's receive pins
module spi_far_end (
  // pins toward the port
  output logic sck,
  output logic sdi,
  // pin from the port
  input wire logic sdo
);
  logic [7:0] heard; // bits taken from the port, last eight
  // idle low between frames
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
    heard = 8'h00;
  end
  // one byte, msb first, 160 ns bit time, data changed on the falling edge
  task automatic send(input logic [7:0] value);
    for (int i = 7; i >= 0; i--) begin
      sdi = value[i];
      #80 sck = 1'b1;
      heard = {heard[6:0], sdo}; // port launched this bit on the falling edge
      #80 sck = 1'b0;
    end
    // released line shows the inverse of the last bit
    sdi = ~value[0];
  endtask
endmodule
`default_nettype wire

// file: test/sync_serial_status_config_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "sync_serial_defines.svh"
module sync_serial_status_config_bench
  import sync_serial_pkg::*;
;
  logic clock, reset, clock_enable, write_strobe, read_strobe, rx_ready;
  logic [7:0] address, write_data, read_data, rx_data;
  logic sck_out, sck_oe, sdo, slew_control_enable, rx_valid;
  wire logic sck_in, sdi; // driven by the far-side model
  int n_fail, comparisons, n;
  logic [31:0] seed;
  logic [7:0] v, b0, b1;
  // design under test
  sync_serial_port dut (.clock(clock), .reset(reset), .clock_enable(clock_enable),
    .address(address), .write_data(write_data), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .read_data(read_data), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe(sck_oe), .sdi(sdi), .sdo(sdo),
    .slew_control_enable(slew_control_enable), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data));
  spi_far_end far (.sck(sck_in), .sdi(sdi), .sdo(sdo));
  // 100 mhz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // pseudo-random step
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // status value expected after a write, with buffer state
  function automatic logic [7:0] status_exp(input logic [7:0] w, input logic full);
    return (w & `STATUS_WRITE_MASK) | {7'h00, full};
  endfunction
  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask
  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 d = read_data;
  endtask
  // wait for a buffered byte, compare it, then take it
  task automatic drain(input logic [7:0] e);
    int k;
    k = 0;
    #1;
    while (rx_valid !== 1'b1 && k < 1000) begin
      @(posedge clock);
      #1 k++;
    end
    check({7'h00, rx_valid}, 8'h01);
    check(rx_data, e);
    @(posedge clock) rx_ready <= 1'b1;
    @(posedge clock) rx_ready <= 1'b0;
    @(posedge clock);
  endtask
  // slew output after a sample bit setting
  task automatic slew(input logic [7:0] ctrl, input logic [7:0] st, output logic [7:0] s);
    wr(`SERIAL_PORT_CONTROL_ADDR, ctrl);
    wr(`SERIAL_PORT_STATUS_ADDR, st);
    repeat (3) @(posedge clock);
    #1 s = {7'h00, slew_control_enable};
  endtask
  // counts and verdict
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial begin
    {address, write_data, write_strobe, read_strobe, rx_ready} = '0;
    clock_enable = 1'b1;
    reset = 1'b1;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    rd(`SERIAL_PORT_STATUS_ADDR, v);
    check(v, 8'h00);
    seed = 86288;
    // random writes keep only the upper two bits
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      wr(`SERIAL_PORT_STATUS_ADDR, seed[7:0]);
      rd(`SERIAL_PORT_STATUS_ADDR, v);
      check(v, status_exp(seed[7:0], 1'b0));
    end
    wr(8'h55, 8'hff);
    rd(8'h55, v);
    check(v, 8'h00);
    $display("register test done");
    slew(8'h21, 8'h00, v);
    check(v, 8'h01);
    slew(8'h21, 8'h80, v);
    check(v, 8'h00);
    // spi slave until the master test, sample bit kept clear
    slew(8'h20, 8'h00, v);
    check(v, 8'h00);
    $display("slew test done");
    // two random bytes while the receiver stalls
    seed = lfsr(seed);
    b0 = seed[7:0];
    seed = lfsr(seed);
    b1 = seed[7:0];
    far.send(b0);
    far.send(b1);
    check(far.heard, b0);
    repeat (10) @(posedge clock);
    rd(`SERIAL_PORT_STATUS_ADDR, v);
    check(v, status_exp(8'h00, 1'b1));
    drain(b0);
    drain(b1);
    rd(`SERIAL_PORT_STATUS_ADDR, v);
    check(v, 8'h00);
    $display("stream test done");
    // a frozen clock enable drops a status write
    @(posedge clock) clock_enable <= 1'b0;
    wr(`SERIAL_PORT_STATUS_ADDR, 8'h40);
    @(posedge clock) clock_enable <= 1'b1;
    rd(`SERIAL_PORT_STATUS_ADDR, v);
    check(v, 8'h00);
    // master: idle level while off, then generated clock with end sampling
    wr(`SERIAL_PORT_CONTROL_ADDR, 8'h12);
    wr(`SERIAL_PORT_STATUS_ADDR, 8'hc0);
    repeat (3) @(posedge clock);
    #1 check({6'h00, sck_oe, sck_out}, 8'h01);
    wr(`SERIAL_PORT_CONTROL_ADDR, 8'h02);
    wr(`SERIAL_PORT_CONTROL_ADDR, 8'h22);
    repeat (4) @(posedge clock);
    #1 check({7'h00, sck_oe}, 8'h01);
    for (int j = 0; j < 2; j++) begin
      v = {7'h00, sck_out};
      n = 0;
      while (sck_out === v[0] && n < 40) begin
        @(posedge clock);
        #1 n++;
      end
    end
    check(n[7:0], {4'h0, `HALF_PERIOD_CYCLES});
    drain({8{~b1[0]}});
    $display("master test done");
    give_verdict();
  end
  // hang guard, about 20000 cycles
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire
